/* tb.sv */
// Testbench for the external memory bus interface with a memory model.
// Assumes the design package and all design files are compiled first.
`timescale 1ns/1ps
module tb;
	logic        clock_in = 0, nrst_in = 0, req = 0, we = 0, nram = 0;
	logic        ale, rd_n, wr_n, ext, done, m_oe, strobed = 0;
	logic        kb = 0, keep, en_o;
	logic [3:0]  hr = 0;
	logic [7:0]  plv = 8'h3c;
	logic [7:0]  ca = 0, wd = 0, bus, last = 0, m_out, hi_seen = 0;
	logic [7:0]  dout, oe, upo, upoe, rdata;
	logic [15:0] addr = 0;
	logic [1:0]  wl = 0, wu = 0;
	int          bad_count = 0, checked = 0, n, i;
	initial forever #10 clock_in = ~clock_in;
	assign bus = (oe & dout) |
		(~oe & (m_oe ? m_out : (keep ? last : ~last)));
	always @(posedge clock_in) last <= bus;
	always @(negedge clock_in) if (!rd_n || !wr_n) begin
		strobed = 1;
		hi_seen = upo;
	end
	xmi_top xmi_top_i (.clock_in(clock_in), .nrst_in(nrst_in),
		.ext_mem_ctrl_a_in(ca), .ext_mem_ctrl_b_in({kb, 7'h00}),
		.sector_limit_in(16'hc000), .ws_lower_in(wl), .ws_upper_in(wu),
		.hi_release_in(hr), .int_top_in(16'h2200), .req_in(req),
		.we_in(we), .addr_in(addr), .wdata_in(wd), .next_ram_in(nram),
		.port_lo_val_in(plv), .port_lo_dir_in(8'h0f),
		.port_hi_val_in(8'hc3), .port_hi_dir_in(8'hf0),
		.muxed_low_bus_in(bus), .muxed_low_bus_out(dout),
		.muxed_low_bus_oe_out(oe), .muxed_keeper_out(keep),
		.upper_addr_lines_out(upo), .upper_addr_lines_oe_out(upoe),
		.ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n), .ext_out(ext),
		.done_out(done), .rdata_out(rdata),
		.off_chip_enable_bit_out(en_o));
	xmi_sram_model xmi_sram_model_i (.ale_in(ale), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .bus_in(bus), .bus_out(m_out),
		.bus_oe_out(m_oe));
	task chk(input logic [15:0] seen, input logic [15:0] exp,
		input string name);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		we = w;
		addr = a;
		wd = d;
		req = 1;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clock_in);
			n++;
		end
		req = 0;
		repeat (2) @(negedge clock_in);
	endtask : acc
	task pair(input logic w, input int k);
		wl = k[1:0];
		wu = 2'h3 - k[1:0];
		nram = k[0];
		acc(w, 16'h8000 + k[15:0], 8'h5a ^ k[7:0]);
		chk(n, 3 + k, "lower wait");
		if (!w) chk(rdata, 8'h5a ^ k[7:0], "lower data");
		acc(w, 16'hc010 + k[15:0], 8'ha5 ^ k[7:0]);
		chk(n, 6 - k, "upper wait");
		if (!w) chk(rdata, 8'ha5 ^ k[7:0], "upper data");
	endtask : pair
	task print_verdict;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2000) @(posedge clock_in);
		bad_count++;
		print_verdict;
	end
	initial begin
		repeat (20) @(negedge clock_in);
		nrst_in = 1;
		@(negedge clock_in);
		acc(1, 16'h8001, 8'h77);
		chk(n, 20, "refused access");
		chk(oe, 8'h0f, "low dir");
		chk(upo, 8'hc3, "high val");
		chk(upoe, 8'hf0, "high dir");
		plv = 8'ha5;
		@(negedge clock_in);
		chk(dout, 8'ha5, "low val");
		chk(en_o, 1'b0, "enable off");
		ca = 8'h80;
		@(negedge clock_in);
		chk(upoe, 8'hff, "high override");
		chk(en_o, 1'b1, "enable on");
		chk(keep, 1'b0, "keeper off");
		kb = 1;
		@(negedge clock_in);
		chk(keep, 1'b1, "keeper on");
		for (i = 0; i < 4; i++) pair(1, i);
		chk(bus, 8'ha6, "kept bus");
		chk(hi_seen, 8'hc0, "upper address");
		for (i = 0; i < 4; i++) pair(0, i);
		strobed = 0;
		acc(0, 16'h0100, 8'h00);
		chk(strobed, 1'b0, "internal strobes");
		chk(n < 20, 1'b1, "internal done");
		hr = 4'h4;
		@(negedge clock_in);
		chk(upo, 8'hc1, "released lines");
		print_verdict;
	end
endmodule : tb
bind xmi_top xmi_checker xmi_checker_i (.clock_in(clock_in),
	.nrst_in(nrst_in), .ext_mem_ctrl_a_in(ext_mem_ctrl_a_in),
	.addr_in(addr_in), .wdata_in(wdata_in),
	.muxed_low_bus_out(muxed_low_bus_out),
	.muxed_low_bus_oe_out(muxed_low_bus_oe_out), .ale_out(ale_out),
	.rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .ext_out(ext_out),
	.done_out(done_out));

/* xmi_cfg_if.sv */
// Interface carrying decoded configuration between top and decoder.
// Assumes driver is the top module and consumer is the decoder.
`timescale 1ns/1ps
interface xmi_cfg_if;
	logic [15:0] addr;
	logic [15:0] sector_limit;
	logic [1:0]  ws_lower;
	logic [1:0]  ws_upper;
	logic [15:0] int_top;
	logic        enable;
	logic        is_ext;
	logic [1:0]  ws_sel;
	modport top (output addr, sector_limit, ws_lower, ws_upper, int_top,
		enable, input is_ext, ws_sel);
	modport dec (input addr, sector_limit, ws_lower, ws_upper, int_top,
		enable, output is_ext, ws_sel);
endinterface : xmi_cfg_if

/* xmi_checker_properties.sv */
// Concurrent checks on the external memory bus interface top ports.
// Assumes it is bound to xmi_top and sees only that module's ports.
`timescale 1ns/1ps
module xmi_checker (
	input wire logic       clock_in,
	input wire logic       nrst_in,
	input wire logic [7:0] ext_mem_ctrl_a_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] muxed_low_bus_out,
	input wire logic [7:0] muxed_low_bus_oe_out,
	input wire logic       ale_out,
	input wire logic       rd_n_out,
	input wire logic       wr_n_out,
	input wire logic       ext_out,
	input wire logic       done_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	a_strobe_excl: assert property (rd_n_out || wr_n_out)
		else $error("both strobes low");
	a_ale_data_low: assert property (!(rd_n_out && wr_n_out) |-> !ale_out)
		else $error("latch strobe high in data phase");
	a_disabled_quiet: assert property (!ext_mem_ctrl_a_in[7] |->
		rd_n_out && wr_n_out)
		else $error("strobe while disabled");
	a_internal_quiet: assert property (!ext_out |-> rd_n_out && wr_n_out)
		else $error("strobe on internal access");
	a_done_on_end: assert property ($rose(rd_n_out) || $rose(wr_n_out)
		|-> done_out)
		else $error("data phase end without done");
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	a_strobe_bound: assert property ($fell(rd_n_out) || $fell(wr_n_out)
		|-> ##[1:4] (rd_n_out && wr_n_out))
		else $error("strobe too long");
	a_write_data: assert property (!wr_n_out |-> muxed_low_bus_out ==
		wdata_in && muxed_low_bus_oe_out == 8'hff)
		else $error("write data not on bus");
	a_addr_at_fall: assert property ($fell(ale_out) && !(rd_n_out &&
		wr_n_out) |-> $past(muxed_low_bus_out) == addr_in[7:0])
		else $error("low address not valid at latch fall");
	c_read: cover property ($rose(rd_n_out) && done_out);
	c_write: cover property ($rose(wr_n_out) && done_out);
	c_internal: cover property (done_out && !ext_out);
endmodule : xmi_checker

/* xmi_decode.sv */
// Address decoder: internal/external and per-sector wait-state pick.
// Assumes configuration is stable during an access.
`timescale 1ns/1ps
module xmi_decode
	import xmi_pkg::*;
(
	xmi_cfg_if.dec cfg
);
	always_comb begin
		// Never aliases onto internal memory when disabled
		cfg.is_ext = cfg.enable && (cfg.addr >= cfg.int_top);
		if (cfg.addr >= cfg.sector_limit) begin
			cfg.ws_sel = cfg.ws_upper;
		end else begin
			cfg.ws_sel = cfg.ws_lower;
		end
	end
endmodule : xmi_decode

/* xmi_pkg.sv */
// Package for the external memory bus interface: constants and types.
// Assumes a 16-bit data address space and an 8-bit data path.
package xmi_pkg;
	localparam int XMI_ADDR_W      = 16;
	localparam int XMI_DATA_W      = 8;
	localparam int XMI_HI_W        = 8;
	// Default end of internal data memory (last internal address + 1)
	localparam logic [15:0] XMI_INT_TOP_RST = 16'h2200;
	// Wait-state codes, two bits each
	localparam logic [1:0] XMI_WS_NONE = 2'h0;
	localparam logic [1:0] XMI_WS_MAX  = 2'h3;
	// Field positions inside the configuration words
	localparam int XMI_CFG_ENABLE  = 7;
	localparam int XMI_CFG_KEEPER  = 7;
	localparam logic [7:0] XMI_CTRL_A_RST = 8'h00;
	localparam logic [7:0] XMI_CTRL_B_RST = 8'h00;

	typedef enum logic [4:0] {
		XMI_IDLE  = 5'b00001,
		XMI_ADDR  = 5'b00010,
		XMI_WAIT  = 5'b00100,
		XMI_DATA  = 5'b01000,
		XMI_END   = 5'b10000
	} xmi_state_e;
endpackage : xmi_pkg

/* xmi_sram_model.sv */
// External byte memory behind a transparent address latch.
// Assumes the bench resolves the shared bus from both drivers.
`timescale 1ns/1ps
module xmi_sram_model (
	input wire logic       ale_in,
	input wire logic       rd_n_in,
	input wire logic       wr_n_in,
	input wire logic [7:0] bus_in,
	output logic [7:0]     bus_out,
	output logic           bus_oe_out
);
	logic [7:0] mem [256];
	logic [7:0] adr;
	always_latch if (ale_in) adr <= bus_in;
	always_latch if (!wr_n_in) mem[adr] <= bus_in;
	assign bus_oe_out = !rd_n_in;
	assign bus_out = mem[adr];
endmodule : xmi_sram_model

/* xmi_top.sv */
// External memory bus interface top: strobes, muxed bus, pin override.
// Assumes the CPU holds req_in, addr_in, wdata_in until done_out pulses.
//
// Operation
// - Low address byte first, then data, on one eight-bit muxed bus.
// - Upper address byte on dedicated lines; number of lines selectable.
// - Low address valid on muxed bus when latch strobe falls.
// - Latch strobe stays low for the whole data phase.
// - Address decides internal or external; external drives pins.
// - Internal access may show bus activity but read/write strobes stay high.
// - Enabled interface overrides direction of its dedicated pins.
// - Disabled interface returns pins to ordinary port value and direction.
// - Disabled: addresses above internal memory do not alias inside.
// - Enabled: space beyond internal memory reached through external pins.
// - Four wait-state settings, one with no wait state.
// - External space split into two sectors, each own wait setting.
// - Optional bus keepers on muxed lines, software switched.
// - Interface enabled only by the enable bit of control word A.
// - External access takes one extra cycle per wait state, and no extra cycle with none.
// - Enabled keeper holds last driven muxed value while undriven.
// - Final latch pulse only when the next access also targets RAM.
`timescale 1ns/1ps
module xmi_top
	import xmi_pkg::*;
#(
	parameter int HI_W = XMI_HI_W
)(
	input  wire logic              clock_in,
	input  wire logic              nrst_in,
	input  wire logic [7:0]        ext_mem_ctrl_a_in,
	input  wire logic [7:0]        ext_mem_ctrl_b_in,
	input  wire logic [15:0]       sector_limit_in,
	input  wire logic [1:0]        ws_lower_in,
	input  wire logic [1:0]        ws_upper_in,
	input  wire logic [3:0]        hi_release_in,
	input  wire logic [15:0]       int_top_in,
	input  wire logic              req_in,
	input  wire logic              we_in,
	input  wire logic [15:0]       addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              next_ram_in,
	input  wire logic [7:0]        port_lo_val_in,
	input  wire logic [7:0]        port_lo_dir_in,
	input  wire logic [HI_W-1:0]   port_hi_val_in,
	input  wire logic [HI_W-1:0]   port_hi_dir_in,
	input  wire logic [7:0]        muxed_low_bus_in,
	output logic [7:0]             muxed_low_bus_out,
	output logic [7:0]             muxed_low_bus_oe_out,
	output logic                   muxed_keeper_out,
	output logic [HI_W-1:0]        upper_addr_lines_out,
	output logic [HI_W-1:0]        upper_addr_lines_oe_out,
	output logic                   ale_out,
	output logic                   rd_n_out,
	output logic                   wr_n_out,
	output logic                   ext_out,
	output logic                   done_out,
	output logic [7:0]             rdata_out,
	output logic                   off_chip_enable_bit_out
);
	xmi_cfg_if cfg ();

	xmi_state_e   state;
	logic [1:0]   wait_cnt;
	logic         acc_ext;
	logic         acc_we;
	logic [15:0]  acc_addr;
	logic [7:0]   acc_wdata;
	logic         bus_drive;
	logic [7:0]   bus_q;
	logic [7:0]   keep_q;
	logic         enable;
	logic [HI_W-1:0] hi_mask;

	assign enable = ext_mem_ctrl_a_in[XMI_CFG_ENABLE];
	assign off_chip_enable_bit_out = enable;
	assign muxed_keeper_out = enable && ext_mem_ctrl_b_in[XMI_CFG_KEEPER];

	assign cfg.addr         = addr_in;
	assign cfg.sector_limit = sector_limit_in;
	assign cfg.ws_lower     = ws_lower_in;
	assign cfg.ws_upper     = ws_upper_in;
	assign cfg.int_top      = int_top_in;
	assign cfg.enable       = enable;

	xmi_decode u_dec (
		.cfg (cfg)
	);

	function automatic logic [HI_W-1:0] hi_lines(input logic [3:0] rel);
		logic [HI_W-1:0] m;
		m = '1;
		for (int i = 0; i < HI_W; i++) begin
			if (i >= HI_W - int'(rel)) begin
				m[i] = 1'b0;
			end
		end
		return m;
	endfunction : hi_lines

	assign hi_mask = hi_lines(hi_release_in);

	// Access sequencer
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state     <= XMI_IDLE;
			wait_cnt  <= XMI_WS_NONE;
			acc_ext   <= 1'b0;
			acc_we    <= 1'b0;
			acc_addr  <= 16'h0000;
			acc_wdata <= 8'h00;
		end else begin
			case (state)
				XMI_IDLE: begin
					if (req_in && enable) begin
						acc_ext   <= cfg.is_ext;
						acc_we    <= we_in;
						acc_addr  <= addr_in;
						acc_wdata <= wdata_in;
						wait_cnt  <= cfg.ws_sel;
						state     <= XMI_ADDR;
					end
				end
				XMI_ADDR: begin
					state <= (acc_ext && wait_cnt != XMI_WS_NONE) ?
						XMI_WAIT : XMI_DATA;
				end
				XMI_WAIT: begin
					wait_cnt <= wait_cnt - 2'h1;
					if (wait_cnt == 2'h1) begin
						state <= XMI_DATA;
					end
				end
				XMI_DATA: begin
					state <= XMI_END;
				end
				XMI_END: begin
					state <= XMI_IDLE;
				end
				default: begin
					state <= XMI_IDLE;
				end
			endcase
		end
	end

	// Pin drivers
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ale_out   <= 1'b0;
			rd_n_out  <= 1'b1;
			wr_n_out  <= 1'b1;
			bus_q     <= 8'h00;
			bus_drive <= 1'b0;
			done_out  <= 1'b0;
			rdata_out <= 8'h00;
		end else begin
			done_out <= 1'b0;
			case (state)
				XMI_IDLE: begin
					// Latch gate opens while the address is put out
					ale_out   <= req_in && enable;
					bus_q     <= addr_in[7:0];
					bus_drive <= req_in && enable;
					rd_n_out  <= 1'b1;
					wr_n_out  <= 1'b1;
				end
				XMI_ADDR: begin
					ale_out   <= 1'b0;
					bus_drive <= acc_we;
					bus_q     <= acc_we ? acc_wdata : acc_addr[7:0];
					if (acc_ext && !(wait_cnt != XMI_WS_NONE)) begin
						rd_n_out <= acc_we;
						wr_n_out <= !acc_we;
					end else if (acc_ext) begin
						rd_n_out <= acc_we;
						wr_n_out <= !acc_we;
					end
				end
				XMI_WAIT: begin
					ale_out <= 1'b0;
				end
				XMI_DATA: begin
					ale_out  <= 1'b0;
					rd_n_out <= 1'b1;
					wr_n_out <= 1'b1;
					if (!acc_we) begin
						rdata_out <= muxed_low_bus_in;
					end
					done_out <= 1'b1;
				end
				XMI_END: begin
					// Trailing latch pulse only if RAM is touched next
					ale_out   <= next_ram_in;
					bus_drive <= 1'b0;
				end
				default: begin
					ale_out <= 1'b0;
				end
			endcase
		end
	end

	// Keeper remembers the last value seen on the muxed bus
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			keep_q <= 8'h00;
		end else if (bus_drive) begin
			keep_q <= bus_q;
		end else begin
			keep_q <= muxed_low_bus_in;
		end
	end

	// Pin ownership and direction override
	always_comb begin
		if (enable) begin
			// Keeper is a weak hold outside the pad, never a driver
			muxed_low_bus_oe_out    = {8{bus_drive}};
			muxed_low_bus_out       = bus_drive ? bus_q : keep_q;
			upper_addr_lines_oe_out = hi_mask | (port_hi_dir_in & ~hi_mask);
			upper_addr_lines_out    = (acc_addr[15:16-HI_W] & hi_mask) |
				(port_hi_val_in & ~hi_mask);
		end else begin
			muxed_low_bus_oe_out    = port_lo_dir_in;
			muxed_low_bus_out       = port_lo_val_in;
			upper_addr_lines_oe_out = port_hi_dir_in;
			upper_addr_lines_out    = port_hi_val_in;
		end
	end

	assign ext_out = acc_ext && (state != XMI_IDLE);
endmodule : xmi_top
